//--- verilog/sdm_pkg.sv
// Constants, field layouts and types of the DAC mode-control block.
// What this block does
// - Per-channel soft-mute bit, resets to zero.
// - Mute ramps attenuation down every eight samples.
// - Unmute ramps back up every eight samples.
// - Oversampling bit selects 64x or 128x.
// - Channel disable forces output to midscale.
// - De-emphasis enable bit, default bypass.
// - Two-bit de-emphasis rate, code three reserved.
// - Three-bit audio format, resets to left-justified.
// - Rolloff bit selects sharp or slow.
// - Output-phase bit inverts both channels together.
// - Flag polarity bit: high or low active.
// - Grouping bit: separate flags or one common.
// - Zero detect after 1024 zero samples.
// - Zero-flag pin asserted while zero detected.
// - Word: zero, 7-bit index, 8-bit data.
package sdm_pkg;

   localparam int WORD_W = 16;
   localparam int IDX_W = 7;
   localparam int DATA_W = 8;
   localparam int SAMPLE_W = 24;
   localparam int ZCNT_W = 11;
   localparam int STEP_W = 3;

   // Control word layout.
   localparam int WORD_ZERO_BIT = 15;
   localparam int IDX_MSB = 14;
   localparam int IDX_LSB = 8;
   localparam int DATA_MSB = 7;

   // Register indices.
   localparam logic [IDX_W-1:0] IDX_LEFT_ATTEN = 7'h10;
   localparam logic [IDX_W-1:0] IDX_RIGHT_ATTEN = 7'h11;
   localparam logic [IDX_W-1:0] IDX_MUTE_OVERSAMPLE = 7'h12;
   localparam logic [IDX_W-1:0] IDX_DAC_DEEMPHASIS = 7'h13;
   localparam logic [IDX_W-1:0] IDX_FORMAT_FILTER = 7'h14;
   localparam logic [IDX_W-1:0] IDX_PHASE_FLAG = 7'h16;

   // Field positions inside the data byte.
   localparam int LEFT_MUTE_BIT = 0;
   localparam int RIGHT_MUTE_BIT = 1;
   localparam int OVERSAMPLE_BIT = 6;
   localparam int LEFT_DISABLE_BIT = 0;
   localparam int RIGHT_DISABLE_BIT = 1;
   localparam int DEEMPH_EN_BIT = 4;
   localparam int DEEMPH_RATE_LSB = 5;
   localparam int DEEMPH_RATE_MSB = 6;
   localparam int FORMAT_LSB = 0;
   localparam int FORMAT_MSB = 2;
   localparam int ROLLOFF_BIT = 5;
   localparam int INVERT_BIT = 0;
   localparam int POLARITY_BIT = 1;
   localparam int GROUPING_BIT = 2;

   // Attenuator codes and timing counts in sample periods.
   localparam logic [DATA_W-1:0] ATTEN_RESET = 8'hFF;
   localparam logic [DATA_W-1:0] ATTEN_MUTE = 8'h80;
   localparam logic [DATA_W-1:0] ATTEN_STEP = 8'h01;
   localparam logic [STEP_W-1:0] STEP_LAST = 3'h7;
   localparam logic [STEP_W-1:0] STEP_ONE = 3'h1;
   localparam logic [ZCNT_W-1:0] ZERO_PERIOD = 11'h400;
   localparam logic [ZCNT_W-1:0] ZCNT_ONE = 11'h001;

   // Sample arithmetic for phase inversion.
   localparam logic [SAMPLE_W-1:0] SAMPLE_MIN = 24'h800000;
   localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 24'h7FFFFF;
   localparam logic [SAMPLE_W-1:0] SAMPLE_ONE = 24'h000001;

   typedef enum logic [1:0]
   {
      RATE_44K1 = 2'b00,
      RATE_48K = 2'b01,
      RATE_32K = 2'b10,
      RATE_RSVD = 2'b11
   } sdm_deemph_rate_t;

   typedef enum logic [2:0]
   {
      FMT_RJ24 = 3'b000,
      FMT_RJ20 = 3'b001,
      FMT_RJ18 = 3'b010,
      FMT_RJ16 = 3'b011,
      FMT_I2S = 3'b100,
      FMT_LJ = 3'b101,
      FMT_RSVD6 = 3'b110,
      FMT_RSVD7 = 3'b111
   } sdm_format_t;

   typedef struct packed
   {
      logic left_soft_mute;
      logic right_soft_mute;
      logic oversample_128;
      logic left_channel_disable;
      logic right_channel_disable;
      logic deemphasis_enable;
      sdm_deemph_rate_t deemphasis_rate_sel;
      sdm_format_t audio_format_sel;
      logic rolloff_sel;
      logic output_invert;
      logic flag_polarity_sel;
      logic flag_grouping_sel;
   } sdm_mode_t;

   localparam sdm_mode_t MODE_RESET = '{
      left_soft_mute: 1'b0,
      right_soft_mute: 1'b0,
      oversample_128: 1'b0,
      left_channel_disable: 1'b0,
      right_channel_disable: 1'b0,
      deemphasis_enable: 1'b0,
      deemphasis_rate_sel: RATE_44K1,
      audio_format_sel: FMT_LJ,
      rolloff_sel: 1'b0,
      output_invert: 1'b0,
      flag_polarity_sel: 1'b0,
      flag_grouping_sel: 1'b0
   };

endpackage

//--- verilog/sdm_atten_ramp.sv
// One channel's attenuator that walks one step per eight sample periods.
`timescale 1ns/1ps
module sdm_atten_ramp
   import sdm_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Sample tick and settings.
   input wire logic tick,
   input wire logic mute,
   input wire logic [DATA_W-1:0] level,
   // Present attenuator code.
   output logic [DATA_W-1:0] current
);

   logic [STEP_W-1:0] div_q;
   logic [DATA_W-1:0] cur_q;
   logic [DATA_W-1:0] target;
   logic step_now;

   // Muting aims at the first infinite code unless already below it.
   assign target = (mute && level > ATTEN_MUTE) ? ATTEN_MUTE : level;
   assign step_now = tick && (div_q == STEP_LAST);
   assign current = cur_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         div_q <= '0;
      else if (tick)
         div_q <= div_q + STEP_ONE;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cur_q <= ATTEN_RESET;
      else if (step_now && cur_q > target)
         cur_q <= cur_q - ATTEN_STEP;
      else if (step_now && cur_q < target)
         cur_q <= cur_q + ATTEN_STEP;
   end

   a_ramp_step_size: assert property (@(posedge clk)
      disable iff (!rst_n)
      cur_q != $past(cur_q) |-> $past(step_now) &&
      (cur_q == $past(cur_q) + ATTEN_STEP ||
       cur_q == $past(cur_q) - ATTEN_STEP))
      else $error("Attenuator moved off a step boundary.");

   a_ramp_toward_target: assert property (@(posedge clk)
      disable iff (!rst_n)
      step_now && cur_q != target |=> cur_q != $past(cur_q))
      else $error("Attenuator failed to step toward its target.");

endmodule

//--- verilog/sdm_zero_detect.sv
// One channel's counter of consecutive zero samples.
`timescale 1ns/1ps
module sdm_zero_detect
   import sdm_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Sample tick and zero test.
   input wire logic tick,
   input wire logic is_zero,
   // Zero-detect condition.
   output logic detect
);

   logic [ZCNT_W-1:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else if (tick && !is_zero)
         cnt_q <= '0;
      else if (tick && cnt_q != ZERO_PERIOD)
         cnt_q <= cnt_q + ZCNT_ONE;
   end

   assign detect = (cnt_q == ZERO_PERIOD);

   a_zero_clear_now: assert property (@(posedge clk)
      disable iff (!rst_n)
      tick && !is_zero |=> !detect)
      else $error("Nonzero sample did not clear zero detect.");

   a_zero_needs_count: assert property (@(posedge clk)
      disable iff (!rst_n)
      $rose(detect) |-> $past(tick) && $past(is_zero) &&
      $past(cnt_q) == ZERO_PERIOD - ZCNT_ONE)
      else $error("Zero detect rose before the full count.");

endmodule

//--- verilog/sdm_mode_ctrl.sv
// Mode-control registers, serial control port and zero flags of the DAC.
`timescale 1ns/1ps
module sdm_mode_ctrl
   import sdm_pkg::*;
(
   // Clock and reset.
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // Three-wire serial control port.
   input wire logic CTRL_DATA,
   input wire logic CTRL_CLK,
   input wire logic CTRL_LATCH,
   // Audio sample side.
   input wire logic WORD_CLOCK,
   input wire logic [SAMPLE_W-1:0] LEFT_SAMPLE,
   input wire logic [SAMPLE_W-1:0] RIGHT_SAMPLE,
   // Settings to the converter path.
   output sdm_mode_t MODE,
   output logic [DATA_W-1:0] LEFT_ATTEN_CURRENT,
   output logic [DATA_W-1:0] RIGHT_ATTEN_CURRENT,
   output logic [SAMPLE_W-1:0] LEFT_OUTPUT,
   output logic [SAMPLE_W-1:0] RIGHT_OUTPUT,
   // Zero-flag pins.
   output logic LEFT_ZERO_FLAG,
   output logic RIGHT_ZERO_FLAG
);

   // Pin synchronisers: data, clock, latch, word clock.
   logic [3:0] pin_meta_q;
   logic [3:0] pin_sync_q;
   logic [3:0] pin_prev_q;
   logic data_s;
   logic sclk_rise;
   logic latch_rise;
   logic tick;

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
         pin_prev_q <= '0;
      end
      else
      begin
         pin_meta_q <= {WORD_CLOCK, CTRL_LATCH, CTRL_CLK, CTRL_DATA};
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   assign data_s = pin_sync_q[0];
   assign sclk_rise = pin_sync_q[1] && !pin_prev_q[1];
   assign latch_rise = pin_sync_q[2] && !pin_prev_q[2];
   assign tick = pin_sync_q[3] && !pin_prev_q[3];

   // Serial shift register, most significant bit first.
   logic [WORD_W-1:0] shift_q;
   logic [IDX_W-1:0] word_idx;
   logic [DATA_W-1:0] word_data;
   logic word_ok;

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         shift_q <= '0;
      else if (sclk_rise)
         shift_q <= {shift_q[WORD_W-2:0], data_s};
   end

   assign word_idx = shift_q[IDX_MSB:IDX_LSB];
   assign word_data = shift_q[DATA_MSB:0];
   // A word with bit 15 set is not a register write and is dropped.
   assign word_ok = latch_rise && !shift_q[WORD_ZERO_BIT];

   logic wr_left_atten;
   logic wr_right_atten;
   logic wr_mute;
   logic wr_dac;
   logic wr_fmt;
   logic wr_flag;

   assign wr_left_atten = word_ok && word_idx == IDX_LEFT_ATTEN;
   assign wr_right_atten = word_ok && word_idx == IDX_RIGHT_ATTEN;
   assign wr_mute = word_ok && word_idx == IDX_MUTE_OVERSAMPLE;
   assign wr_dac = word_ok && word_idx == IDX_DAC_DEEMPHASIS;
   assign wr_fmt = word_ok && word_idx == IDX_FORMAT_FILTER;
   assign wr_flag = word_ok && word_idx == IDX_PHASE_FLAG;

   // Reserved bits are not stored; the host keeps them at zero.
   logic [DATA_W-1:0] left_level_q;
   logic [DATA_W-1:0] right_level_q;
   sdm_mode_t mode_q;

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         left_level_q <= ATTEN_RESET;
         right_level_q <= ATTEN_RESET;
      end
      else
      begin
         if (wr_left_atten)
            left_level_q <= word_data;
         if (wr_right_atten)
            right_level_q <= word_data;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         mode_q.left_soft_mute <= MODE_RESET.left_soft_mute;
         mode_q.right_soft_mute <= MODE_RESET.right_soft_mute;
         mode_q.oversample_128 <= MODE_RESET.oversample_128;
      end
      else if (wr_mute)
      begin
         mode_q.left_soft_mute <= word_data[LEFT_MUTE_BIT];
         mode_q.right_soft_mute <= word_data[RIGHT_MUTE_BIT];
         mode_q.oversample_128 <= word_data[OVERSAMPLE_BIT];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         mode_q.left_channel_disable <= MODE_RESET.left_channel_disable;
         mode_q.right_channel_disable <= MODE_RESET.right_channel_disable;
         mode_q.deemphasis_enable <= MODE_RESET.deemphasis_enable;
         mode_q.deemphasis_rate_sel <= MODE_RESET.deemphasis_rate_sel;
      end
      else if (wr_dac)
      begin
         mode_q.left_channel_disable <= word_data[LEFT_DISABLE_BIT];
         mode_q.right_channel_disable <= word_data[RIGHT_DISABLE_BIT];
         mode_q.deemphasis_enable <= word_data[DEEMPH_EN_BIT];
         mode_q.deemphasis_rate_sel <= sdm_deemph_rate_t'(
            word_data[DEEMPH_RATE_MSB:DEEMPH_RATE_LSB]);
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         mode_q.audio_format_sel <= MODE_RESET.audio_format_sel;
         mode_q.rolloff_sel <= MODE_RESET.rolloff_sel;
      end
      else if (wr_fmt)
      begin
         mode_q.audio_format_sel <= sdm_format_t'(
            word_data[FORMAT_MSB:FORMAT_LSB]);
         mode_q.rolloff_sel <= word_data[ROLLOFF_BIT];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         mode_q.output_invert <= MODE_RESET.output_invert;
         mode_q.flag_polarity_sel <= MODE_RESET.flag_polarity_sel;
         mode_q.flag_grouping_sel <= MODE_RESET.flag_grouping_sel;
      end
      else if (wr_flag)
      begin
         mode_q.output_invert <= word_data[INVERT_BIT];
         mode_q.flag_polarity_sel <= word_data[POLARITY_BIT];
         mode_q.flag_grouping_sel <= word_data[GROUPING_BIT];
      end
   end

   assign MODE = mode_q;

   // Attenuators with soft-mute ramps.
   sdm_atten_ramp u_left_ramp
   (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .tick(tick),
      .mute(mode_q.left_soft_mute),
      .level(left_level_q),
      .current(LEFT_ATTEN_CURRENT)
   );

   sdm_atten_ramp u_right_ramp
   (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .tick(tick),
      .mute(mode_q.right_soft_mute),
      .level(right_level_q),
      .current(RIGHT_ATTEN_CURRENT)
   );

   // Phase inversion saturates the one code with no positive twin.
   function automatic logic [SAMPLE_W-1:0] phase_adj(
      input logic [SAMPLE_W-1:0] s,
      input logic inv
   );
      logic [SAMPLE_W-1:0] r;
      r = s;
      if (inv && s == SAMPLE_MIN)
         r = SAMPLE_MAX;
      else if (inv)
         r = ~s + SAMPLE_ONE;
      return r;
   endfunction

   logic [SAMPLE_W-1:0] left_out_q;
   logic [SAMPLE_W-1:0] right_out_q;

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         left_out_q <= '0;
         right_out_q <= '0;
      end
      else if (tick)
      begin
         // A disabled channel sits at bipolar zero, code zero.
         left_out_q <= mode_q.left_channel_disable ? '0 :
            phase_adj(LEFT_SAMPLE, mode_q.output_invert);
         right_out_q <= mode_q.right_channel_disable ? '0 :
            phase_adj(RIGHT_SAMPLE, mode_q.output_invert);
      end
   end

   assign LEFT_OUTPUT = left_out_q;
   assign RIGHT_OUTPUT = right_out_q;

   // Zero detection judges each channel on its own.
   logic left_zero;
   logic right_zero;

   sdm_zero_detect u_left_zero
   (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .tick(tick),
      .is_zero(LEFT_SAMPLE == '0),
      .detect(left_zero)
   );

   sdm_zero_detect u_right_zero
   (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .tick(tick),
      .is_zero(RIGHT_SAMPLE == '0),
      .detect(right_zero)
   );

   logic right_pin_active;
   logic left_pin_active;
   logic right_pin_q;
   logic left_pin_q;

   // In common mode the right pin carries both, the left pin idles.
   assign right_pin_active = mode_q.flag_grouping_sel ?
      (left_zero && right_zero) : right_zero;
   assign left_pin_active = mode_q.flag_grouping_sel ? 1'b0 : left_zero;

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         right_pin_q <= 1'b0;
         left_pin_q <= 1'b0;
      end
      else
      begin
         right_pin_q <= right_pin_active ^ mode_q.flag_polarity_sel;
         left_pin_q <= left_pin_active ^ mode_q.flag_polarity_sel;
      end
   end

   assign RIGHT_ZERO_FLAG = right_pin_q;
   assign LEFT_ZERO_FLAG = left_pin_q;

   // Checks.
   a_flag_follows_detect: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      !mode_q.flag_grouping_sel && !mode_q.flag_polarity_sel ##1
      !$changed(mode_q) |-> RIGHT_ZERO_FLAG == $past(right_zero))
      else $error("Right zero flag does not follow its detect.");

   a_flag_polarity: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      mode_q.flag_polarity_sel && !mode_q.flag_grouping_sel |=>
      LEFT_ZERO_FLAG == !$past(left_zero) &&
      RIGHT_ZERO_FLAG == !$past(right_zero))
      else $error("Inverted flag polarity not applied.");

   a_flag_common: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      mode_q.flag_grouping_sel && !mode_q.flag_polarity_sel &&
      (left_zero != right_zero) |=> !RIGHT_ZERO_FLAG)
      else $error("Common flag asserted with one channel live.");

   a_left_pin_idle: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      mode_q.flag_grouping_sel |=>
      LEFT_ZERO_FLAG == $past(mode_q.flag_polarity_sel))
      else $error("Left flag pin not idle in common mode.");

   a_shift_bit_in: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      sclk_rise |=> shift_q[0] == $past(data_s))
      else $error("Serial bit not shifted in.");

   a_write_addressed: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      word_ok && word_idx != IDX_FORMAT_FILTER |=>
      $stable(mode_q.audio_format_sel))
      else $error("Unaddressed register changed.");

   a_write_bit15: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      latch_rise && shift_q[WORD_ZERO_BIT] |=> $stable(mode_q))
      else $error("Word with bit 15 set was written.");

   a_format_write: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      wr_fmt |=> mode_q.audio_format_sel ==
      $past(word_data[FORMAT_MSB:FORMAT_LSB]))
      else $error("Format field did not take the written code.");

   a_mute_write: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      wr_mute |=>
      mode_q.left_soft_mute == $past(word_data[LEFT_MUTE_BIT]) &&
      mode_q.right_soft_mute == $past(word_data[RIGHT_MUTE_BIT]))
      else $error("Soft-mute bits did not take the written value.");

   a_invert_output: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      tick && !mode_q.right_channel_disable && mode_q.output_invert &&
      RIGHT_SAMPLE != SAMPLE_MIN |=>
      RIGHT_OUTPUT == ~$past(RIGHT_SAMPLE) + SAMPLE_ONE)
      else $error("Inverted phase output is not the negated sample.");

   sequence s_disable_set;
      mode_q.left_channel_disable && tick;
   endsequence

   a_disable_midscale: assert property (@(posedge SYS_CLK)
      disable iff (!RESET_N)
      s_disable_set |=> LEFT_OUTPUT == '0)
      else $error("Disabled channel not at midscale.");

endmodule

//--- tb/sdm_host_model.sv
// Behavioural host that writes words over the three-wire control port.
`timescale 1ns/1ps
module sdm_host_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Request from the bench.
   input wire logic start,
   input wire logic [15:0] word,
   output logic done,
   // Serial control pins.
   output logic ctrl_data,
   output logic ctrl_clk,
   output logic ctrl_latch
);
   // Each level is held four cycles, one more than the port needs.
   localparam int HOLD = 4;

   initial
   begin
      done = 1'h0;
      ctrl_data = 1'h1;
      ctrl_clk = 1'h0;
      ctrl_latch = 1'h0;
   end

   always @(posedge clk)
   begin
      if (rst_n && start && !done)
      begin
         for (int i = 15; i >= 0; i--)
         begin
            ctrl_data <= word[i];
            repeat (HOLD) @(posedge clk);
            ctrl_clk <= 1'h1;
            repeat (HOLD) @(posedge clk);
            ctrl_clk <= 1'h0;
         end
         // The released data line shows the inverse of its last bit.
         ctrl_data <= ~word[0];
         repeat (HOLD) @(posedge clk);
         ctrl_latch <= 1'h1;
         repeat (HOLD) @(posedge clk);
         ctrl_latch <= 1'h0;
         repeat (HOLD) @(posedge clk);
         done <= 1'h1;
         @(posedge clk);
         done <= 1'h0;
      end
   end
endmodule

//--- tb/stereo_dac_mode_control_zero_flags_bench.sv
// Self-checking bench for the DAC mode registers, ramps and zero flags.
`timescale 1ns/1ps
module stereo_dac_mode_control_zero_flags_bench
   import sdm_pkg::*;
;
   localparam int LIMIT = 40000;
   logic clk, rst_n, hstart, hdone, sdata, sclk, slatch, wclk;
   logic [15:0] hword;
   logic [SAMPLE_W-1:0] lsmp, rsmp, lout, rout;
   logic [DATA_W-1:0] latt, ratt;
   logic lflag, rflag;
   sdm_mode_t mode, em;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;

   sdm_host_model host (
      .clk(clk), .rst_n(rst_n), .start(hstart), .word(hword),
      .done(hdone), .ctrl_data(sdata), .ctrl_clk(sclk),
      .ctrl_latch(slatch)
   );

   sdm_mode_ctrl DUT (
      .SYS_CLK(clk), .RESET_N(rst_n), .CTRL_DATA(sdata),
      .CTRL_CLK(sclk), .CTRL_LATCH(slatch), .WORD_CLOCK(wclk),
      .LEFT_SAMPLE(lsmp), .RIGHT_SAMPLE(rsmp), .MODE(mode),
      .LEFT_ATTEN_CURRENT(latt), .RIGHT_ATTEN_CURRENT(ratt),
      .LEFT_OUTPUT(lout), .RIGHT_OUTPUT(rout),
      .LEFT_ZERO_FLAG(lflag), .RIGHT_ZERO_FLAG(rflag)
   );

   initial
   begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         miscompares++;
         results();
      end
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] want);
      comparisons++;
      if (got !== want)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   // Sends one control word and waits for the host to finish.
   task automatic wr(input logic [15:0] w);
      int n;
      @(posedge clk);
      hword <= w;
      hstart <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hdone !== 1'h1 && n < 400);
      hstart <= 1'h0;
      chk(hdone, 1'h1);
      repeat (2) @(posedge clk);
   endtask

   // Each sample period lasts seven clocks, above the six required.
   task automatic smp(input logic [23:0] l, input logic [23:0] r, int cnt);
      repeat (cnt)
      begin
         @(posedge clk);
         lsmp <= l;
         rsmp <= r;
         wclk <= 1'h1;
         repeat (3) @(posedge clk);
         wclk <= 1'h0;
         repeat (3) @(posedge clk);
      end
   endtask

   initial
   begin
      rst_n = 1'h0;
      hstart = 1'h0;
      hword = '0;
      wclk = 1'h0;
      lsmp = '0;
      rsmp = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      repeat (4) @(posedge clk);
      em = '0;
      em.audio_format_sel = FMT_LJ;
      chk(mode, em);
      chk({latt, ratt}, 16'hFFFF);
      chk({lflag, rflag}, 2'h0);
      wr({1'h0, IDX_LEFT_ATTEN, 8'h82});
      wr({1'h0, IDX_RIGHT_ATTEN, 8'h82});
      smp(24'h000100, 24'h000100, 1);
      smp('0, '0, 1023);
      chk({lflag, rflag}, 2'h0);
      smp('0, '0, 1);
      chk({lflag, rflag}, 2'h3);
      chk({latt, ratt}, 16'h8282);
      wr({1'h0, IDX_PHASE_FLAG, 8'h04});
      smp('0, '0, 1);
      chk({lflag, rflag}, 2'h1);
      smp(24'h000001, '0, 1);
      chk({lflag, rflag}, 2'h0);
      wr({1'h0, IDX_PHASE_FLAG, 8'h00});
      smp('0, '0, 1);
      chk({lflag, rflag}, 2'h1);
      wr({1'h0, IDX_PHASE_FLAG, 8'h02});
      smp('0, '0, 1);
      chk({lflag, rflag}, 2'h2);
      wr({1'h0, IDX_PHASE_FLAG, 8'h00});
      smp('0, '0, 1021);
      chk({lflag, rflag}, 2'h1);
      smp('0, '0, 1);
      chk({lflag, rflag}, 2'h3);
      wr({1'h0, IDX_MUTE_OVERSAMPLE, 8'h01});
      smp('0, '0, 8);
      chk({latt, ratt}, 16'h8182);
      smp('0, '0, 8);
      chk({latt, ratt}, 16'h8082);
      smp('0, '0, 8);
      chk({latt, ratt}, 16'h8082);
      wr({1'h0, IDX_MUTE_OVERSAMPLE, 8'h00});
      smp('0, '0, 8);
      chk({latt, ratt}, 16'h8182);
      smp('0, '0, 16);
      chk({latt, ratt}, 16'h8282);
      smp(24'h123456, 24'h0ABCDE, 1);
      chk({lout, rout}, 48'h1234560ABCDE);
      wr({1'h0, IDX_PHASE_FLAG, 8'h01});
      smp(24'h123456, 24'h0ABCDE, 1);
      chk({lout, rout}, {24'h0 - 24'h123456, 24'h0 - 24'h0ABCDE});
      wr({1'h0, IDX_DAC_DEEMPHASIS, 8'h01});
      smp(24'h123456, 24'h0ABCDE, 1);
      chk({lout, rout}, {24'h0, 24'h0 - 24'h0ABCDE});
      em.output_invert = 1'h1;
      em.left_channel_disable = 1'h1;
      for (int f = 0; f < 6; f++)
      begin
         wr({1'h0, IDX_FORMAT_FILTER, 2'h0, f[0], 2'h0, f[2:0]});
         em.audio_format_sel = sdm_format_t'(f[2:0]);
         em.rolloff_sel = f[0];
         chk(mode, em);
      end
      for (int r = 0; r < 3; r++)
      begin
         wr({1'h0, IDX_DAC_DEEMPHASIS, 1'h0, r[1:0], ~r[0], 2'h0, r[1:0]});
         em.deemphasis_rate_sel = sdm_deemph_rate_t'(r[1:0]);
         em.deemphasis_enable = ~r[0];
         em.left_channel_disable = r[0];
         em.right_channel_disable = r[1];
         chk(mode, em);
      end
      for (int z = 7; z >= 0; z -= 7)
      begin
         wr({1'h0, IDX_PHASE_FLAG, 5'h00, z[2:0]});
         em.flag_grouping_sel = z[2];
         em.flag_polarity_sel = z[1];
         em.output_invert = z[0];
         chk(mode, em);
      end
      for (int m = 3; m >= 0; m -= 3)
      begin
         wr({1'h0, IDX_MUTE_OVERSAMPLE, 1'h0, m[0], 4'h0, m[1:0]});
         em.oversample_128 = m[0];
         em.left_soft_mute = m[0];
         em.right_soft_mute = m[1];
         chk(mode, em);
      end
      wr({1'h1, IDX_FORMAT_FILTER, 8'h00});
      chk(mode, em);
      wr({1'h0, 7'h15, 8'h07});
      wr({1'h0, 7'h17, 8'h07});
      chk(mode, em);
      smp(24'h123456, 24'h0ABCDE, 1);
      chk({lout, rout}, 48'h123456000000);
      wr({1'h0, IDX_MUTE_OVERSAMPLE, 8'h02});
      smp('0, '0, 16);
      chk({latt, ratt}, 16'h8280);
      results();
   end
endmodule
